// File: core/acted_defs.svh
`ifndef ACTED_DEFS_SVH
`define ACTED_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define ACTED_CFG_ADDR 8'h1d
`define ACTED_SRC_ADDR 8'h1e
`define ACTED_THS_ADDR 8'h1f
`define ACTED_CNT_ADDR 8'h20

// ************************************************************
// field positions and reset values
// ************************************************************
`define ACTED_CFG_HPF_BYP 0
`define ACTED_CFG_XEN 1
`define ACTED_CFG_YEN 2
`define ACTED_CFG_ZEN 3
`define ACTED_CFG_LATCH 4
`define ACTED_CFG_MASK 8'h1f
`define ACTED_CFG_RESET 8'h00
`define ACTED_THS_MODE 7
`define ACTED_THS_RESET 8'h00
`define ACTED_CNT_RESET 8'h00

// ************************************************************
// threshold scale: 63 mg per count, samples in counts of this many ug
// ************************************************************
`define ACTED_THS_MG_PER_LSB 63
`define ACTED_SAMPLE_UG_PER_LSB 977
`define ACTED_HPF_SHIFT 4

`endif

// File: core/acted_pkg.sv
package acted_pkg;

  typedef struct packed {
    logic signed [13:0] x;
    logic signed [13:0] y;
    logic signed [13:0] z;
  } acted_sample_type;

  typedef struct packed {
    logic [6:0] threshold;
    logic clear_mode;
    logic [7:0] debounce;
    logic [2:0] axis_en;
    logic bypass;
  } acted_ctrl_type;

  typedef enum logic [1:0] {
    ACTED_IDLE,
    ACTED_ARMED,
    ACTED_FIRED
  } acted_state_type;

endpackage

// File: core/acted_hpf.sv
`include "acted_defs.svh"

module acted_hpf (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire acted_pkg::acted_sample_type sample_in,
  input wire logic bypass_in,
  output acted_pkg::acted_sample_type data_out
);

  // ************************************************************
  // first-order high-pass: subtract a leaky running mean
  // ************************************************************
  logic signed [13:0] mean_q [3];
  logic signed [13:0] mean_d [3];
  logic signed [13:0] raw [3];
  logic signed [13:0] delta [3];

  function automatic logic signed [13:0] hp_step(input logic signed [13:0] m,
                                                 input logic signed [13:0] s);
    logic signed [14:0] diff;
    diff = 15'(s) - 15'(m);
    hp_step = m + 14'(diff >>> `ACTED_HPF_SHIFT);
  endfunction

  always_comb
  begin
    raw[0] = sample_in.x;
    raw[1] = sample_in.y;
    raw[2] = sample_in.z;
    for (int i = 0; i < 3; i++)
    begin
      mean_d[i] = tick_in ? hp_step(mean_q[i], raw[i]) : mean_q[i];
      delta[i] = 14'(raw[i] - mean_q[i]);
    end
    // bypass feeds raw samples, else dc-free deltas
    data_out.x = bypass_in ? raw[0] : delta[0];
    data_out.y = bypass_in ? raw[1] : delta[1];
    data_out.z = bypass_in ? raw[2] : delta[2];
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 3; i++)
        mean_q[i] <= 14'h0000;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        mean_q[i] <= mean_d[i];
    end
  end

endmodule

// File: core/acted_detector.sv
// Contract
// - bypass bit 0 filters samples through the high-pass; 1 passes them raw.
// - filtered mode compares dc-free deltas; bypass compares raw values like motion.
// - event when any enabled axis exceeds threshold for the debounce count.
// - per-axis enable bits; 0 disables that axis, 1 lets it raise events.
// - latch off: interrupt flag follows the real-time detector status.
// - latch on: flag holds once set until host reads the source register.
// - config register resets to zero; top three bits reserved.
// - threshold is 7-bit unsigned at 63 mg per count, range independent.
// - failing period decrements debounce counter, or clears it when mode bit set.
// - 8-bit debounce count sets minimum periods above threshold before flagging.
// - source flags clear only on host read; unlatched events keep updating them.
`include "acted_defs.svh"

module acted_detector (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic odr_tick_in,
  input wire acted_pkg::acted_sample_type sample_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic event_out
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] ths_q, ths_d;
  logic [7:0] cnt_q, cnt_d;
  logic [6:0] src_q, src_d;
  logic [7:0] dbc_q, dbc_d;
  logic ev_q, ev_d;
  logic [7:0] rdata_q, rdata_d;
  acted_pkg::acted_state_type st_q, st_d;
  acted_pkg::acted_ctrl_type ctrl;
  acted_pkg::acted_sample_type fdata;
  logic [2:0] over;
  logic [2:0] neg;
  logic cond;
  logic src_rd;
  logic signed [13:0] axis [3];

  always_comb
  begin
    ctrl.threshold = ths_q[6:0];
    ctrl.clear_mode = ths_q[`ACTED_THS_MODE];
    ctrl.debounce = cnt_q;
    ctrl.axis_en = cfg_q[`ACTED_CFG_ZEN:`ACTED_CFG_XEN];
    ctrl.bypass = cfg_q[`ACTED_CFG_HPF_BYP];
  end

  acted_hpf u_hpf (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .tick_in(odr_tick_in),
    .sample_in(sample_in),
    .bypass_in(ctrl.bypass),
    .data_out(fdata)
  );

  // ************************************************************
  // threshold compare
  // ************************************************************
  // threshold in sample counts: ths * 63 mg scaled to sample lsb
  function automatic logic [13:0] ths_counts(input logic [6:0] t);
    logic [31:0] p;
    p = 32'(t) * 32'(`ACTED_THS_MG_PER_LSB * 1000) / 32'(`ACTED_SAMPLE_UG_PER_LSB);
    ths_counts = (p > 32'h0000_1fff) ? 14'h1fff : p[13:0];
  endfunction

  function automatic logic [13:0] mag(input logic signed [13:0] v);
    mag = v[13] ? 14'(-v) : v;
  endfunction

  // raise the summary and the flags of the axes now over, keep the rest until read
  function automatic logic [6:0] src_merge(input logic [6:0] s, input logic [2:0] o,
                                           input logic [2:0] n);
    logic [6:0] r;
    r = s;
    r[6] = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      if (o[i])
      begin
        r[2 * i + 1] = 1'b1;
        r[2 * i] = n[i];
      end
    end
    src_merge = r;
  endfunction

  always_comb
  begin
    axis[0] = fdata.x;
    axis[1] = fdata.y;
    axis[2] = fdata.z;
    for (int i = 0; i < 3; i++)
    begin
      neg[i] = axis[i][13];
      over[i] = ctrl.axis_en[i] && (mag(axis[i]) > ths_counts(ctrl.threshold));
    end
    cond = |over;
  end

  // ************************************************************
  // debounce and event flag
  // ************************************************************
  assign src_rd = reg_rd_in && (reg_addr_in == `ACTED_SRC_ADDR);

  always_comb
  begin
    dbc_d = dbc_q;
    st_d = st_q;
    ev_d = ev_q;
    src_d = src_q;
    if (src_rd)
    begin
      src_d = 7'h00;
      if (cfg_q[`ACTED_CFG_LATCH])
        ev_d = 1'b0;
    end
    if (odr_tick_in)
    begin
      if (cond)
      begin
        if (dbc_q < ctrl.debounce)
          dbc_d = dbc_q + 8'h01;
      end
      else if (ctrl.clear_mode)
        dbc_d = 8'h00;
      else if (dbc_q != 8'h00)
        dbc_d = dbc_q - 8'h01;
      unique case (st_q)
        acted_pkg::ACTED_IDLE:
          if (cond)
            st_d = acted_pkg::ACTED_ARMED;
        acted_pkg::ACTED_ARMED, acted_pkg::ACTED_FIRED:
          if (!cond && dbc_d == 8'h00)
            st_d = acted_pkg::ACTED_IDLE;
      endcase
      if (cond && (dbc_q >= ctrl.debounce || dbc_q + 8'h01 >= ctrl.debounce))
      begin
        st_d = acted_pkg::ACTED_FIRED;
        // latched and set: keep the first flags; a read in this cycle loses to the set
        if (!(cfg_q[`ACTED_CFG_LATCH] && ev_q) || src_rd)
          src_d = src_merge(src_d, over, neg);
        ev_d = 1'b1;
      end
      else if (!cfg_q[`ACTED_CFG_LATCH])
        ev_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      src_q <= 7'h00;
      dbc_q <= 8'h00;
      ev_q <= 1'b0;
      st_q <= acted_pkg::ACTED_IDLE;
    end
    else
    begin
      src_q <= src_d;
      dbc_q <= dbc_d;
      ev_q <= ev_d;
      st_q <= st_d;
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  always_comb
  begin
    cfg_d = cfg_q;
    ths_d = ths_q;
    cnt_d = cnt_q;
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        `ACTED_CFG_ADDR: cfg_d = reg_wdata_in & `ACTED_CFG_MASK;
        `ACTED_THS_ADDR: ths_d = reg_wdata_in;
        `ACTED_CNT_ADDR: cnt_d = reg_wdata_in;
        default: cfg_d = cfg_q;
      endcase
    end
    unique case (reg_addr_in)
      `ACTED_CFG_ADDR: rdata_d = cfg_q;
      `ACTED_SRC_ADDR: rdata_d = {1'b0, src_q};
      `ACTED_THS_ADDR: rdata_d = ths_q;
      `ACTED_CNT_ADDR: rdata_d = cnt_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_q <= `ACTED_CFG_RESET;
      ths_q <= `ACTED_THS_RESET;
      cnt_q <= `ACTED_CNT_RESET;
      rdata_q <= 8'h00;
    end
    else
    begin
      cfg_q <= cfg_d;
      ths_q <= ths_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign event_out = ev_q;

endmodule

// File: dv/acted_checker.sv
module acted_checker (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic odr_tick_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic event_out
);
  // ****
  // shadow of the config register
  // ****
  logic [4:0] cfg_q;
  logic [4:0] cfg_d;
  always_comb
  begin
    cfg_d = cfg_q;
    if (reg_wr_in && reg_addr_in == 8'h1d)
    begin
      cfg_d = reg_wdata_in[4:0];
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_q <= 5'h00;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence tick_seen;
    $past(odr_tick_in) || $past(odr_tick_in, 2);
  endsequence
  sequence fall_cause;
    $past(odr_tick_in) || $past(odr_tick_in, 2) || $past(reg_rd_in) || $past(reg_rd_in, 2);
  endsequence
  sequence src_read;
    reg_rd_in && reg_addr_in == 8'h1e && cfg_q[4];
  endsequence
  reset_zero_a: assert property ($fell(rst_in) |-> !event_out && reg_rdata_out == 8'h00)
    else $error("outputs not zero after reset");
  cfg_readback_a: assert property (!reg_wr_in && reg_addr_in == 8'h1d |=>
    reg_rdata_out == {3'b000, $past(cfg_q)}) else $error("config readback wrong");
  src_summary_a: assert property (reg_addr_in == 8'h1e |=> !reg_rdata_out[7] &&
    reg_rdata_out[6] == (reg_rdata_out[5] | reg_rdata_out[3] | reg_rdata_out[1]))
    else $error("source summary bit wrong");
  rise_tick_a: assert property ($rose(event_out) |-> tick_seen)
    else $error("event rose without a tick");
  rise_axis_a: assert property ($rose(event_out) |-> $past(cfg_q[3:1]) != 3'b000)
    else $error("event rose with all axes disabled");
  fall_cause_a: assert property ($fell(event_out) |-> fall_cause)
    else $error("event fell without tick or read");
  latch_hold_a: assert property (cfg_q[4] && event_out && !reg_wr_in && !reg_rd_in &&
    !$past(reg_rd_in) |=> event_out) else $error("latched event dropped");
  latch_clear_a: assert property (src_read ##0 !odr_tick_in && !$past(odr_tick_in) |->
    ##[1:2] !event_out) else $error("latched event not cleared by read");
endmodule

bind acted_detector acted_checker chk_u (.core_clk_in, .rst_in, .odr_tick_in, .reg_wr_in,
  .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .event_out);

// File: dv/acted_host.sv
module acted_host (
  input wire logic core_clk_in,
  input wire logic [7:0] rdata_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge core_clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  // reading the source register is how the host clears flags
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge core_clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask
endmodule

// File: dv/ac_transient_event_detector_tb.sv
module ac_transient_event_detector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] cfg; logic [41:0] s; logic ev;} acted_row_type;
  localparam logic [13:0] pos = 14'h00c8;
  localparam logic [13:0] neg = 14'h3f38;
  localparam logic [13:0] zro = 14'h0000;
  localparam logic [41:0] xp = {pos, zro, zro};
  acted_row_type rows [8] = '{{8'h03, pos, zro, zro, 1'b1}, {8'h05, pos, zro, zro, 1'b0},
    {8'h05, zro, neg, zro, 1'b1}, {8'h09, zro, zro, pos, 1'b1}, {8'h01, pos, pos, pos, 1'b0},
    {8'h03, 14'h0040, zro, zro, 1'b0}, {8'h03, 14'h0041, zro, zro, 1'b1},
    {8'h03, neg, zro, zro, 1'b1}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tick = 1'b0;
  logic wr, rd, ev;
  logic [7:0] addr, wd, rdat, v;
  acted_pkg::acted_sample_type smp = '0;
  int n_mismatch = 0;
  int n_compared = 0;
  acted_detector dut_u (.core_clk_in(clk), .rst_in(rst), .odr_tick_in(tick), .sample_in(smp),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .event_out(ev));
  acted_host host_u (.core_clk_in(clk), .rdata_in(rdat), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wd));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic pulse(input logic [41:0] s);
    @(posedge clk);
    tick <= 1'b1;
    smp <= s;
    @(posedge clk);
    tick <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    forever #20 clk = ~clk;
  end
  initial
  begin
    #100us;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      host_u.rd(8'h1d + 8'(i), v);
      chk(v, 8'h00);
    end
    host_u.wr(8'h1d, 8'hff);
    host_u.rd(8'h1d, v);
    chk(v, 8'h1f);
    host_u.wr(8'h1d, 8'h02);
    host_u.wr(8'h1f, 8'h01);
    pulse(xp);
    chk(ev, 1'b1);
    repeat (40) pulse(xp);
    chk(ev, 1'b0);
    host_u.wr(8'h1d, 8'h03);
    pulse(xp);
    chk(ev, 1'b1);
    pulse('0);
    host_u.rd(8'h1e, v);
    foreach (rows[i])
    begin
      host_u.wr(8'h1d, rows[i].cfg);
      pulse(rows[i].s);
      chk(ev, rows[i].ev);
      pulse('0);
      host_u.rd(8'h1e, v);
      chk(v[6], rows[i].ev);
    end
    host_u.wr(8'h1d, 8'h07);
    pulse(xp);
    pulse({zro, neg, zro});
    host_u.rd(8'h1e, v);
    chk(v, 8'h4e);
    for (int m = 0; m < 2; m++)
    begin
      host_u.wr(8'h1f, {m[0], 7'h01});
      host_u.wr(8'h20, 8'h03);
      repeat (3) pulse('0);
      repeat (2) pulse(xp);
      chk(ev, 1'b0);
      pulse('0);
      repeat (2) pulse(xp);
      chk(ev, !m[0]);
      pulse(xp);
      chk(ev, 1'b1);
      repeat (4) pulse('0);
      host_u.rd(8'h1e, v);
    end
    host_u.wr(8'h20, 8'h00);
    host_u.wr(8'h1d, 8'h13);
    pulse({neg, zro, zro});
    pulse('0);
    chk(ev, 1'b1);
    host_u.rd(8'h1e, v);
    chk(v, 8'h43);
    @(posedge clk);
    #1 chk(ev, 1'b0);
    host_u.rd(8'h1e, v);
    chk(v, 8'h00);
    pulse({neg, zro, zro});
    chk(ev, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(ev, 1'b0);
    host_u.rd(8'h1d, v);
    chk(v, 8'h00);
    host_u.rd(8'h1e, v);
    chk(v, 8'h00);
    summarize();
  end
endmodule
